// ===== logic/ais_consts.svh
// Named offsets, field positions, reset values for the input sequencer.
// Assumes inclusion by the package, the top module and the bench.
`ifndef AIS_CONSTS_SVH
`define AIS_CONSTS_SVH
// Register byte offsets
`define AIS_OFF_CTRL 8'h00
`define AIS_OFF_QLOAD 8'h04
`define AIS_OFF_STAT 8'h08
`define AIS_OFF_DATA 8'h0c
`define AIS_OFF_SCAN 8'h10
`define AIS_OFF_SAMP 8'h14
`define AIS_OFF_CPS 8'h18
`define AIS_OFF_IRQEN 8'h1c
// Control bits
`define AIS_C_SWCONV 0
`define AIS_C_ACQ 1
`define AIS_C_STOPSEL 2
`define AIS_C_V16 3
`define AIS_C_QCLR 4
`define AIS_C_FCLR 5
// Status bits
`define AIS_S_EMPTY 0
`define AIS_S_HALF 1
`define AIS_S_FULL 2
`define AIS_S_OVF 3
`define AIS_S_SCAN 4
`define AIS_S_BUSY 5
`define AIS_S_QCNT 16
// Widths and reset values
`define AIS_ENTRY_W 18
`define AIS_MODE_N 5
`define AIS_SCAN_RST 24'h0003e8
`define AIS_SAMP_RST 16'h0064
`define AIS_CPS_RST 16'h0001
`define AIS_RESP_OK 2'b00
`define AIS_RESP_ERR 2'b10
`endif

// ===== logic/ais_pkg.sv
// Types shared by the analog input sequencer.
// Assumes ais_consts.svh is on the include path.
`default_nettype none
`include "ais_consts.svh"
package ais_pkg;
    // Kinds of conversion resource
    typedef enum logic [2:0] {
        AIS_CAL = 3'h0,
        AIS_DIFF = 3'h1,
        AIS_RSE = 3'h2,
        AIS_NRSE = 3'h3,
        AIS_GHOST = 3'h4
    } ais_ctype_t;
    // One configuration queue entry, as written to the load register
    typedef struct packed {
        logic scan_end_marker;
        logic gen_trig;
        logic dither;
        logic bipolar;
        logic [2:0] gain;
        logic [3:0] bank;
        logic [3:0] chan;
        ais_ctype_t ctype;
    } ais_entry_t;
    // Settings driven to the analog front end
    typedef struct packed {
        logic [`AIS_MODE_N-1:0] mode;
        logic [3:0] chan;
        logic [3:0] bank;
        logic [2:0] programmable_gain_amp;
        logic bipolar;
        logic dither;
        logic gen_trig;
    } ais_fe_t;
    // Conversion engine states
    typedef enum logic [2:0] {
        AIS_IDLE = 3'b001,
        AIS_PULSE = 3'b010,
        AIS_WAIT = 3'b100
    } ais_state_t;
endpackage
`default_nettype wire

// ===== logic/ais_top.sv
// Analog input sequencer: config queue, timing, sample FIFO, AXI4-Lite.
// Assumes one 100 MHz clock; converter answers with adc_done on clk.
`default_nettype none
`include "ais_consts.svh"
module ais_top import ais_pkg::*; #(
    parameter int QDEPTH = 512,
    parameter int FDEPTH = 1024,
    parameter int DW = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite write channels
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Converter and front end
    input wire logic convert_in_n,
    input wire logic adc_done,
    input wire logic [DW-1:0] adc_data,
    output logic convert_n,
    output ais_fe_t fe,
    // Interrupt
    output logic irq_output_line_zero
);
    localparam int QAW = $clog2(QDEPTH);
    localparam int FAW = $clog2(FDEPTH);
    logic awready_r, bvalid_r, arready_r, rvalid_r, irq_r, convert_n_r;
    logic [1:0] bresp_r, rresp_r;
    logic [31:0] rdata_r;
    ais_fe_t fe_r;
    logic acq_r, stopsel_r, v16_r, ovf_r, scan_r;
    logic [23:0] scan_per_r, scan_cnt_r;
    logic [15:0] samp_per_r, samp_cnt_r, cps_r, cnv_cnt_r;
    logic [3:0] irqen_r;
    logic [2:0] pin_s_r;
    logic pin_lvl_r;
    ais_state_t state_r;
    ais_entry_t cur_r;
    ais_entry_t q_mem [QDEPTH];
    logic [QAW-1:0] q_rd_r;
    logic [QAW:0] q_cnt_r;
    logic [DW-1:0] f_mem [FDEPTH];
    logic [FAW:0] f_wp_r, f_rp_r;
    wire wr_go = awvalid && wvalid && !awready_r && !bvalid_r;
    wire wr_hs = awready_r;
    wire rd_go = arvalid && !arready_r && !rvalid_r;
    wire rd_hs = arready_r;
    wire [31:0] wmask;
    genvar gi;
    for (gi = 0; gi < 4; gi++) begin : g_lane
        assign wmask[gi*8 +: 8] = {8{wstrb[gi]}};
    end
    wire [31:0] wv = wdata & wmask;
    wire wr_ctrl = wr_hs && awaddr == `AIS_OFF_CTRL;
    wire wr_qload = wr_hs && awaddr == `AIS_OFF_QLOAD;
    wire wr_stat = wr_hs && awaddr == `AIS_OFF_STAT;
    wire wr_scan = wr_hs && awaddr == `AIS_OFF_SCAN;
    wire wr_samp = wr_hs && awaddr == `AIS_OFF_SAMP;
    wire wr_cps = wr_hs && awaddr == `AIS_OFF_CPS;
    wire wr_irqen = wr_hs && awaddr == `AIS_OFF_IRQEN;
    wire wr_map = awaddr[7:2] <= `AIS_OFF_IRQEN >> 2 && awaddr[1:0] == 2'h0;
    wire rd_map = araddr[7:2] <= `AIS_OFF_IRQEN >> 2 && araddr[1:0] == 2'h0;
    wire sw_conv = wr_ctrl && wv[`AIS_C_SWCONV];
    wire q_clr = wr_ctrl && wv[`AIS_C_QCLR];
    wire f_clr = wr_ctrl && wv[`AIS_C_FCLR];
    wire ovf_clr = wr_stat && wv[`AIS_S_OVF];
    // Sample FIFO flags
    wire [FAW:0] f_cnt = f_wp_r - f_rp_r;
    wire sample_queue_empty_flag = f_cnt == '0;
    wire f_full = f_cnt == (FAW+1)'(FDEPTH);
    wire f_half = f_cnt >= (FAW+1)'(FDEPTH / 2);
    wire pop = rd_hs && araddr == `AIS_OFF_DATA && !sample_queue_empty_flag;
    // Queue head and retransmit
    wire q_empty = q_cnt_r == '0;
    ais_entry_t q_head;
    assign q_head = q_empty ? '0 : q_mem[q_rd_r];
    wire [QAW:0] q_next = {1'b0, q_rd_r} + (QAW+1)'(1);
    wire q_retx = q_next == q_cnt_r;
    // Status word; busy while the engine is not idle
    wire busy_w = state_r != AIS_IDLE;
    wire [31:0] stat_w = {6'h00, 10'(q_cnt_r), 10'h000, busy_w, scan_r,
        ovf_r, f_full, f_half, sample_queue_empty_flag};
    wire [31:0] rd_val =
        araddr == `AIS_OFF_CTRL ? {28'h0, v16_r, stopsel_r, acq_r, 1'b0} :
        araddr == `AIS_OFF_STAT ? stat_w :
        araddr == `AIS_OFF_DATA ?
            (sample_queue_empty_flag ? 32'h0 : 32'(f_mem[f_rp_r[FAW-1:0]])) :
        araddr == `AIS_OFF_SCAN ? {8'h00, scan_per_r} :
        araddr == `AIS_OFF_SAMP ? {16'h0000, samp_per_r} :
        araddr == `AIS_OFF_CPS ? {16'h0000, cps_r} :
        araddr == `AIS_OFF_IRQEN ? {28'h0, irqen_r} : 32'h0;

    // Write address and data taken together, then response
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            awready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= `AIS_RESP_OK;
        end else begin
            awready_r <= wr_go;
            if (wr_hs) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_map ? `AIS_RESP_OK : `AIS_RESP_ERR;
            end else if (bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end
    // Read address taken, data registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= `AIS_RESP_OK;
        end else begin
            arready_r <= rd_go;
            if (rd_hs) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_map ? rd_val : 32'h0;
                rresp_r <= rd_map ? `AIS_RESP_OK : `AIS_RESP_ERR;
            end else if (rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end
    // Software settings
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {acq_r, stopsel_r, v16_r} <= 3'h0;
            scan_per_r <= `AIS_SCAN_RST;
            samp_per_r <= `AIS_SAMP_RST;
            cps_r <= `AIS_CPS_RST;
            irqen_r <= 4'h0;
        end else begin
            if (wr_ctrl && wstrb[0]) begin
                acq_r <= wv[`AIS_C_ACQ];
                stopsel_r <= wv[`AIS_C_STOPSEL];
                v16_r <= wv[`AIS_C_V16];
            end
            if (wr_scan)
                scan_per_r <= (scan_per_r & ~wmask[23:0]) | wv[23:0];
            if (wr_samp)
                samp_per_r <= (samp_per_r & ~wmask[15:0]) | wv[15:0];
            if (wr_cps)
                cps_r <= (cps_r & ~wmask[15:0]) | wv[15:0];
            if (wr_irqen && wstrb[0])
                irqen_r <= wv[3:0];
        end
    end
    // External convert pin: three flops, level moves when last two agree
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s_r <= 3'b111;
            pin_lvl_r <= 1'b1;
        end else begin
            pin_s_r <= {pin_s_r[1:0], convert_in_n};
            if (pin_s_r[1] == pin_s_r[2])
                pin_lvl_r <= pin_s_r[2];
        end
    end
    wire pin_fall = pin_lvl_r && !pin_s_r[1] && !pin_s_r[2];
    wire scan_tc = acq_r && scan_cnt_r == 24'h0;
    wire samp_tc = scan_r && samp_cnt_r == 16'h0;
    wire start = state_r == AIS_IDLE && (sw_conv || pin_fall || samp_tc);
    wire done = state_r == AIS_WAIT && adc_done;
    wire ghost = cur_r.ctype == AIS_GHOST;
    wire stop = done && (stopsel_r
        ? cnv_cnt_r + 16'h1 >= cps_r : cur_r.scan_end_marker);
    // Scan, sample and per-scan counters
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scan_cnt_r <= 24'h0;
            samp_cnt_r <= 16'h0;
            cnv_cnt_r <= 16'h0;
            scan_r <= 1'b0;
        end else begin
            if (!acq_r)
                scan_cnt_r <= 24'h0;
            else if (scan_tc)
                scan_cnt_r <= scan_per_r;
            else
                scan_cnt_r <= scan_cnt_r - 24'h1;
            if (scan_tc && !scan_r) begin
                scan_r <= 1'b1;
                samp_cnt_r <= 16'h0;
                cnv_cnt_r <= 16'h0;
            end else begin
                if (stop || !acq_r)
                    scan_r <= 1'b0;
                if (samp_tc)
                    samp_cnt_r <= samp_per_r;
                else if (scan_r)
                    samp_cnt_r <= samp_cnt_r - 16'h1;
                if (done)
                    cnv_cnt_r <= cnv_cnt_r + 16'h1;
            end
        end
    end

    wire [`AIS_MODE_N-1:0] mode_w;
    for (gi = 0; gi < `AIS_MODE_N; gi++) begin : g_mode
        assign mode_w[gi] = q_head.ctype == ais_ctype_t'(3'(gi));
    end
    ais_fe_t fe_nxt;
    assign fe_nxt = '{mode: mode_w, chan: q_head.chan, bank: q_head.bank,
        programmable_gain_amp: v16_r ? {1'b0, q_head.gain[1:0]}
                                     : q_head.gain,
        bipolar: q_head.bipolar, dither: q_head.dither || v16_r,
        gen_trig: q_head.gen_trig};
    // Conversion engine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= AIS_IDLE;
            convert_n_r <= 1'b1;
            cur_r <= '0;
            fe_r <= '0;
        end else begin
            case (state_r)
                AIS_IDLE: begin
                    if (start) begin
                        cur_r <= q_head;
                        fe_r <= fe_nxt;
                        convert_n_r <= 1'b0;
                        state_r <= AIS_PULSE;
                    end
                end
                AIS_PULSE: begin
                    convert_n_r <= 1'b1;
                    state_r <= AIS_WAIT;
                end
                AIS_WAIT: begin
                    if (adc_done)
                        state_r <= AIS_IDLE;
                end
                default: begin
                    convert_n_r <= 1'b1;
                    state_r <= AIS_IDLE;
                end
            endcase
        end
    end
    // Queue pointers; load until full
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_cnt_r <= '0;
            q_rd_r <= '0;
        end else if (q_clr) begin
            q_cnt_r <= '0;
            q_rd_r <= '0;
        end else begin
            if (wr_qload && q_cnt_r < (QAW+1)'(QDEPTH))
                q_cnt_r <= q_cnt_r + (QAW+1)'(1);
            if (start && !q_empty)
                q_rd_r <= q_retx ? '0 : q_next[QAW-1:0];
        end
    end
    always_ff @(posedge clk) begin
        if (wr_qload && !q_clr && q_cnt_r < (QAW+1)'(QDEPTH))
            q_mem[q_cnt_r[QAW-1:0]] <= ais_entry_t'(wv[`AIS_ENTRY_W-1:0]);
    end

    // offset binary to two's complement when bipolar
    wire r12_msb = adc_data[11] ^ cur_r.bipolar;
    wire [DW-1:0] res16 = {adc_data[15] ^ cur_r.bipolar, adc_data[14:0]};
    wire [DW-1:0] res12 = {{4{r12_msb & cur_r.bipolar}}, r12_msb,
        adc_data[10:0]};
    // load strobe, suppressed for discard or full
    wire result_load_strobe_n = !(done && !ghost && !f_full);
    wire ovf_set = done && !ghost && f_full;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            f_wp_r <= '0;
            f_rp_r <= '0;
        end else if (f_clr) begin
            f_wp_r <= '0;
            f_rp_r <= '0;
        end else begin
            // write pointer moves, empty flag drops
            if (!result_load_strobe_n)
                f_wp_r <= f_wp_r + (FAW+1)'(1);
            if (pop)
                f_rp_r <= f_rp_r + (FAW+1)'(1);
        end
    end
    always_ff @(posedge clk) begin
        if (!result_load_strobe_n)
            f_mem[f_wp_r[FAW-1:0]] <= v16_r ? res16 : res12;
    end

    // sticky overflow, set wins; merged interrupt
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovf_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            ovf_r <= ovf_set || (ovf_r && !ovf_clr);
            irq_r <= |({ovf_r, f_full, f_half, !sample_queue_empty_flag}
                & irqen_r);
        end
    end
    // Outputs straight from flops
    assign awready = awready_r;
    assign wready = awready_r;
    assign bvalid = bvalid_r;
    assign bresp = bresp_r;
    assign arready = arready_r;
    assign rvalid = rvalid_r;
    assign rdata = rdata_r;
    assign rresp = rresp_r;
    assign convert_n = convert_n_r;
    assign fe = fe_r;
    assign irq_output_line_zero = irq_r;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_ghost_no_load: assert property (done && ghost |->
        result_load_strobe_n) else $error("discard result was stored");
    a_full_overflow: assert property (done && !ghost && f_full |=>
        ovf_r && $stable(f_wp_r)) else $error("overflow not flagged");
    a_ovf_sticky: assert property (ovf_r && !ovf_clr && !f_clr |=>
        ovf_r) else $error("overflow lost");
    a_load_not_empty: assert property (!result_load_strobe_n
        && !pop && !f_clr |=> !sample_queue_empty_flag)
        else $error("empty flag after load");
    a_pulse_once: assert property ($fell(convert_n_r) |=>
        convert_n_r ##1 convert_n_r) else $error("convert pulse width");
    a_queue_step: assert property (start && !q_empty && !q_retx
        && !q_clr |=> q_rd_r == $past(q_rd_r) + QAW'(1))
        else $error("queue did not advance");
    a_queue_retx: assert property (start && !q_empty && q_retx
        && !q_clr |=> q_rd_r == '0) else $error("no retransmit");
    a_scan_end: assert property (stop && !(scan_tc && !scan_r) |=>
        !scan_r) else $error("scan did not end");
    a_dither_v16: assert property (v16_r && start |=>
        fe_r.dither) else $error("dither off on 16-bit variant");
    a_irq_merge: assert property (irqen_r[2] && f_full |=>
        irq_output_line_zero) else $error("irq not raised");
    c_conv_stored: cover property (!result_load_strobe_n);
    c_retransmit: cover property (start && q_retx && !q_empty);
    c_overflow: cover property (ovf_set);
    c_scan_stop: cover property (stop);
endmodule
`default_nettype wire

// ===== tb/ais_adc_model.sv
// Converter model facing the sequencer's convert and done pins.
// Assumes convert_n is a one-cycle low pulse on clk.
`default_nettype none
module ais_adc_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Converter pins
    input wire logic convert_n,
    output logic adc_done,
    output logic [15:0] adc_data
);
    timeunit 1ns;
    timeprecision 1ps;
    int lat = -1;
    // Answers after zero to three cycles; data churns when not valid
    always @(posedge clk) begin
        adc_done <= 1'b0;
        adc_data <= ~adc_data;
        if (rst) begin
            adc_data <= 16'h0;
            lat <= -1;
        end else if (convert_n == 1'b0) begin
            lat <= $urandom_range(3, 0);
        end else if (lat == 0) begin
            adc_done <= 1'b1;
            adc_data <= 16'($urandom);
            lat <= -1;
        end else if (lat > 0) begin
            lat <= lat - 1;
        end
    end
endmodule
`default_nettype wire

// ===== tb/test_analog_input_sequencer.sv
// Bench for the analog input sequencer: registers, conversions, FIFO, scans.
// Assumes the converter model answers every convert pulse.
`default_nettype none
`include "ais_consts.svh"
module test_analog_input_sequencer import ais_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] BASE = 32'h8; // 16-bit variant selected
    localparam int SAMP = 6;
    logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rv, ctrl_v;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rr;
    logic convert_in_n, adc_done, convert_n, irq_output_line_zero;
    logic [15:0] adc_data;
    logic cur_bip, cur_ghost;
    logic [15:0] expq[$];
    ais_fe_t fe;
    ais_entry_t ent[5];
    int fails, comparisons, nconv, ndone, cyc, last_cv, gap;

    ais_top #(.QDEPTH(512), .FDEPTH(1024), .DW(16)) i_dut (
        .clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .convert_in_n(convert_in_n), .adc_done(adc_done),
        .adc_data(adc_data), .convert_n(convert_n), .fe(fe),
        .irq_output_line_zero(irq_output_line_zero));
    ais_adc_model i_adc (.clk(clk), .rst(rst), .convert_n(convert_n),
        .adc_done(adc_done), .adc_data(adc_data));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Expected sample: bipolar flips sign bit, 12-bit also extends
    function automatic logic [15:0] exp_smp(logic [15:0] d, logic b);
        logic signed [11:0] s;
        s = {d[11] ^ b, d[10:0]};
        if (ctrl_v[`AIS_C_V16])
            return b ? {~d[15], d[14:0]} : d;
        else if (b)
            return 16'(s);
        else
            return {4'h0, d[11:0]};
    endfunction

    // Front-end settings expected for one entry in the current variant
    function automatic logic [31:0] exp_fe(ais_entry_t e);
        ais_fe_t f;
        f.mode = 5'h1 << e.ctype;
        f.chan = e.chan;
        f.bank = e.bank;
        f.programmable_gain_amp = ctrl_v[`AIS_C_V16] ? {1'b0, e.gain[1:0]}
                                                      : e.gain;
        f.bipolar = e.bipolar;
        f.dither = e.dither || ctrl_v[`AIS_C_V16];
        f.gen_trig = e.gen_trig;
        return 32'(f);
    endfunction

    // Counts convert pulses and spacing; queues expected samples
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (convert_n === 1'b0) begin
            nconv <= nconv + 1;
            gap <= cyc - last_cv;
            last_cv <= cyc;
        end
        if (adc_done === 1'b1) begin
            ndone <= ndone + 1;
            if (!cur_ghost && expq.size() < 1024)
                expq.push_back(exp_smp(adc_data, cur_bip));
        end
    end

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rdc(string n, logic [7:0] a, logic [31:0] m,
                       logic [31:0] e);
        rd(a, rv, rr);
        chk(n, e, rv & m);
    endtask

    task automatic rdsmp();
        rd(`AIS_OFF_DATA, rv, rr);
        chk("sample", {16'h0, expq.pop_front()}, rv);
    endtask

    // Waits for a converter answer, then lets the FIFO write land
    task automatic waitd(int n0);
        for (int i = 0; i < 100 && ndone == n0; i++) @(posedge clk);
        chk("conversion done", 32'h1, 32'(ndone != n0));
        repeat (2) @(posedge clk);
    endtask

    task automatic conv(logic ghost, logic bip);
        int n0;
        n0 = ndone;
        cur_ghost = ghost;
        cur_bip = bip;
        wr(`AIS_OFF_CTRL, ctrl_v | 32'h1, rr);
        waitd(n0);
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        summarize();
    end

    initial begin
        ais_entry_t e;
        int n;
        rv = $urandom(7);
        {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hf;
        convert_in_n = 1'b1;
        {cur_bip, cur_ghost} = 2'h0;
        ctrl_v = BASE;
        {fails, comparisons, nconv, ndone, cyc, last_cv, gap} = 224'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        // Reset state, unmapped and misaligned places
        rdc("stat at reset", `AIS_OFF_STAT, 32'hffffffff, 32'h1);
        rd(8'h20, rv, rr);
        chk("unmapped read", 32'h2, {rv[29:0], rr});
        wr(8'h06, 32'h0, rr);
        chk("misaligned write", 32'h2, rr);
        // Variant set before any start so the first entry sees it
        wr(`AIS_OFF_CTRL, BASE, rr);
        rdc("ctrl readback", `AIS_OFF_CTRL, 32'hf, BASE);
        // One entry of every type, then replay of the first
        for (int t = 0; t < 5; t++) begin
            ent[t] = 18'($urandom);
            ent[t].ctype = ais_ctype_t'(t);
            ent[t].scan_end_marker = 1'b0;
            wr(`AIS_OFF_QLOAD, 32'(ent[t]), rr);
        end
        for (int t = 0; t < 6; t++) begin
            e = ent[t % 5];
            conv(t == 4, e.bipolar);
            chk("front end", exp_fe(e), 32'(fe));
            rdc("empty flag", `AIS_OFF_STAT, 32'h1, 32'(t == 4));
            if (t != 4) rdsmp();
        end
        // External pin start uses the next entry
        n = ndone;
        cur_bip = ent[1].bipolar;
        convert_in_n <= 1'b0;
        repeat (3) @(posedge clk);
        convert_in_n <= 1'b1;
        waitd(n);
        chk("pin front end", exp_fe(ent[1]), 32'(fe));
        rdsmp();
        // 12-bit variant: gain and dither follow the entry
        ctrl_v = 32'h0;
        wr(`AIS_OFF_CTRL, ctrl_v, rr);
        cur_bip = ent[2].bipolar;
        conv(1'b0, ent[2].bipolar);
        chk("narrow front end", exp_fe(ent[2]), 32'(fe));
        rdsmp();
        ctrl_v = BASE;
        // Queue capacity, FIFO flags, overflow and interrupt line
        wr(`AIS_OFF_CTRL, BASE | 32'h30, rr);
        expq.delete();
        e = 18'($urandom);
        e.ctype = AIS_DIFF;
        for (int i = 0; i < 513; i++) wr(`AIS_OFF_QLOAD, 32'(e), rr);
        rdc("queue count", `AIS_OFF_STAT, 32'h03ff0000, 32'h02000000);
        wr(`AIS_OFF_IRQEN, 32'h5, rr);
        conv(1'b0, e.bipolar);
        chk("irq not empty", 32'h1, irq_output_line_zero);
        for (int i = 2; i <= 1025; i++) begin
            conv(1'b0, e.bipolar);
            if (i inside {511, 512, 1023, 1024, 1025})
                rdc("fifo flags", `AIS_OFF_STAT, 32'he,
                    {i > 1024, i >= 1024, i >= 512, 1'b0});
        end
        wr(`AIS_OFF_IRQEN, 32'h8, rr);
        repeat (3) @(posedge clk);
        chk("irq overflow", 32'h1, irq_output_line_zero);
        for (int i = 0; i < 1024; i++) rdsmp();
        rdc("overflow held", `AIS_OFF_STAT, 32'h9, 32'h9);
        wr(`AIS_OFF_STAT, 32'h8, rr);
        rdc("overflow cleared", `AIS_OFF_STAT, 32'h9, 32'h1);
        repeat (3) @(posedge clk);
        chk("irq idle", 32'h0, irq_output_line_zero);
        // Timed scans: end marker, then conversions-per-scan count
        wr(`AIS_OFF_SCAN, 32'h3c, rr);
        wr(`AIS_OFF_SAMP, 32'(SAMP), rr);
        wr(`AIS_OFF_CPS, 32'h3, rr);
        for (int s = 0; s < 2; s++) begin
            wr(`AIS_OFF_CTRL, BASE | 32'h30, rr);
            expq.delete();
            for (int t = 0; t < 3; t++) begin
                e = ent[t];
                e.scan_end_marker = (t == 1);
                wr(`AIS_OFF_QLOAD, 32'(e), rr);
            end
            n = nconv;
            wr(`AIS_OFF_CTRL, BASE | 32'h2 | (32'(s) << 2), rr);
            for (int i = 0; i < 500 && nconv < n + 2 + s; i++)
                @(posedge clk);
            repeat (20) @(posedge clk);
            chk("scan length", 2 + s, nconv - n);
            chk("convert spacing", SAMP + 1, gap);
            wr(`AIS_OFF_CTRL, BASE, rr);
        end
        summarize();
    end
endmodule
`default_nettype wire
